// ---- aali_pkg.sv ----
// Package of constants for the antenna axis limit interlock
package aali_pkg;

  // ==========================================================================
  // Register map (word byte offsets)
  localparam logic [7:0] ADDR_MOTION = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_GPIO_OUT = 8'h0C;
  localparam logic [7:0] ADDR_GPIO_OE = 8'h10;
  localparam logic [7:0] ADDR_GPIO_IN = 8'h14;

  // ==========================================================================
  // Motion register fields
  localparam int AZ_CW_BIT = 0;
  localparam int AZ_CCW_BIT = 1;
  localparam int EL_UP_BIT = 2;
  localparam int EL_DN_BIT = 3;
  localparam int POL_CW_BIT = 4;
  localparam int POL_CCW_BIT = 5;
  localparam int AUTO_MOVE_BIT = 6;

  // Config register fields
  localparam int LOCK_SEL_BIT = 0;
  localparam int POL_HV_BIT = 1;

  // Status register fields
  localparam int ST_AZ_STOWED = 0;
  localparam int ST_EL_UP_LIM = 1;
  localparam int ST_EL_BELOW = 2;
  localparam int ST_EL_STOWED = 3;
  localparam int ST_LOCK_ONE = 4;
  localparam int ST_LOCK_TWO = 5;
  localparam int ST_PEAK_QUAL = 6;
  localparam int ST_AMP_INH = 7;

  // ==========================================================================
  // Reset values and widths
  localparam logic [31:0] MOTION_RST = 32'h0000_0000;
  localparam logic [31:0] CONFIG_RST = 32'h0000_0000;
  localparam int GPIO_W = 4;
  localparam logic [3:0] GPIO_RST = 4'h0;

  // Debounce time and derived cycle count at 125 MHz
  localparam int DEB_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int DEB_CYCLES = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : aali_pkg

// ---- aali_top.sv ----
// Axis limit interlock, drive polarity and lock routing with Wishbone registers
//
// The placing of the registers and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// [R1] Closed azimuth stow contact means stowed; open or cut means not stowed.
// [R2] Without azimuth stowed, elevation cannot move below the down limit.
// [R3] Open or cut elevation up contact means at upper limit.
// [R4] At upper limit, upward elevation drive is suppressed.
// [R5] Open or cut elevation down contact means below lower limit.
// [R6] Below lower limit, azimuth drive is suppressed both ways.
// [R7] Open or cut elevation stow contact means elevation stowed.
// [R8] While stowed, downward elevation drive is suppressed.
// [R9] Stowed also forces the below-lower-limit indication.
// [R10] Azimuth clockwise drives positive terminal high; counter-clockwise the negative.
// [R11] Elevation up drives positive terminal high; down the negative.
// [R12] Polarization clockwise: low-voltage variant terminal two high, high-voltage terminal one.
// [R13] Clockwise azimuth must raise sensed azimuth position.
// [R14] Upward elevation must raise look angle and sensed elevation.
// [R15] Northern hemisphere polarization angle grows for satellites farther west.
// [R16] Lock input one pairs with strength channel one, two with two.
// [R17] Configuration picks which lock input qualifies the peaking scan.
// [R18] Four general-purpose digital input/output bits on the strength port.
// [R19] Amplifier inhibit active below lower limit or during large automatic move.
// [R20] Limit contacts are synchronised and debounced before interlock use.
module aali_top #(
  parameter int DEB_CNT = aali_pkg::DEB_CYCLES,
  parameter int GPIO_W = aali_pkg::GPIO_W
) (
  // Clock, enable and reset
  input wire logic clk_i,
  input wire logic ce_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Limit contacts (high = contact closed)
  input wire logic az_stow_closed_i,
  input wire logic el_up_closed_i,
  input wire logic el_dn_closed_i,
  input wire logic el_stow_closed_i,
  // Lock indicators and their strength channel tags
  input wire logic lock_one_i,
  input wire logic lock_two_i,
  output logic strength_chan_one_lock_o,
  output logic strength_chan_two_lock_o,
  output logic peak_qualify_o,
  // Motor terminals
  output logic az_pos_o,
  output logic az_neg_o,
  output logic el_pos_o,
  output logic el_neg_o,
  output logic pol_one_o,
  output logic pol_two_o,
  // Amplifier inhibit
  output logic amplifier_inhibit_o,
  // General purpose bits on the strength port
  input wire logic [GPIO_W-1:0] gpio_i,
  output logic [GPIO_W-1:0] gpio_o,
  output logic [GPIO_W-1:0] gpio_oe_o
);

  // ==========================================================================
  // Contact synchroniser and debounce
  localparam int NSW = 6;
  localparam int CW = $clog2(DEB_CNT + 1);
  logic [NSW-1:0] raw;
  logic [NSW-1:0] s1_q;
  logic [NSW-1:0] s2_q;
  logic [NSW-1:0] s3_q;
  logic [NSW-1:0] deb_q;
  logic [GPIO_W-1:0] g1_q;
  logic [GPIO_W-1:0] g2_q;
  logic [GPIO_W-1:0] g3_q;
  logic [GPIO_W-1:0] gin_q;

  assign raw = {lock_two_i, lock_one_i, el_stow_closed_i, el_dn_closed_i, el_up_closed_i, az_stow_closed_i};

  // Three-stage capture; only the second stage reads the first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      g1_q <= '0;
      g2_q <= '0;
      g3_q <= '0;
    end else if (ce_i) begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      g1_q <= gpio_i;
      g2_q <= g1_q;
      g3_q <= g2_q;
    end
  end

  // Input bits accepted once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gin_q <= '0;
    end else if (ce_i) begin
      for (int k = 0; k < GPIO_W; k++) begin
        if (g2_q[k] == g3_q[k]) begin
          gin_q[k] <= g3_q[k];
        end
      end
    end
  end

  // Per-contact debounce; reset state is all contacts open, the safe reading
  generate
    for (genvar i = 0; i < NSW; i++) begin : g_deb
      logic [CW-1:0] cnt_q;
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          cnt_q <= '0;
          deb_q[i] <= 1'b0;
        end else if (ce_i) begin
          if (s2_q[i] != s3_q[i] || s3_q[i] == deb_q[i]) begin
            cnt_q <= '0; // R20
          end else if (cnt_q == CW'(DEB_CNT - 1)) begin
            cnt_q <= '0;
            deb_q[i] <= s3_q[i]; // R20
          end else begin
            cnt_q <= cnt_q + CW'(1);
          end
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Limit conditions, fail safe when a cable is cut
  logic az_stowed;
  logic el_up_lim;
  logic el_stowed;
  logic el_below;
  assign az_stowed = deb_q[0]; // R1
  assign el_up_lim = ~deb_q[1]; // R3
  assign el_stowed = ~deb_q[3]; // R7
  assign el_below = ~deb_q[2] | el_stowed; // R5 R9

  // ==========================================================================
  // Registers
  logic [31:0] motion_q;
  logic [31:0] config_q;
  logic [GPIO_W-1:0] gpio_out_q;
  logic [GPIO_W-1:0] gpio_oe_q;
  logic wb_req;
  logic wb_wr;
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_req & wb_we_i;

  // Byte-lane merge for a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // One registered ack per request, a cycle after it, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= wb_req;
    end
  end

  // Motion command register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      motion_q <= aali_pkg::MOTION_RST;
    end else if (ce_i && wb_wr && wb_adr_i == aali_pkg::ADDR_MOTION) begin
      motion_q <= merge(motion_q, wb_dat_i, wb_sel_i);
    end
  end

  // Configuration register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      config_q <= aali_pkg::CONFIG_RST;
    end else if (ce_i && wb_wr && wb_adr_i == aali_pkg::ADDR_CONFIG) begin
      config_q <= merge(config_q, wb_dat_i, wb_sel_i);
    end
  end

  // Expansion bits, low byte lane only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gpio_out_q <= aali_pkg::GPIO_RST;
      gpio_oe_q <= aali_pkg::GPIO_RST;
    end else if (ce_i && wb_wr && wb_sel_i[0]) begin
      if (wb_adr_i == aali_pkg::ADDR_GPIO_OUT) begin
        gpio_out_q <= wb_dat_i[GPIO_W-1:0]; // R18
      end
      if (wb_adr_i == aali_pkg::ADDR_GPIO_OE) begin
        gpio_oe_q <= wb_dat_i[GPIO_W-1:0]; // R18
      end
    end
  end

  // ==========================================================================
  // Interlocked motion; opposite requests on one axis cancel for safety
  logic az_cw;
  logic az_ccw;
  logic el_up;
  logic el_dn;
  logic pol_cw;
  logic pol_ccw;
  logic az_ok;
  assign az_ok = ~el_below; // R6
  assign az_cw = motion_q[aali_pkg::AZ_CW_BIT] & ~motion_q[aali_pkg::AZ_CCW_BIT] & az_ok; // R6
  assign az_ccw = motion_q[aali_pkg::AZ_CCW_BIT] & ~motion_q[aali_pkg::AZ_CW_BIT] & az_ok; // R6
  assign el_up = motion_q[aali_pkg::EL_UP_BIT] & ~motion_q[aali_pkg::EL_DN_BIT] & ~el_up_lim; // R4
  // Down is blocked at stow, and below the down limit unless azimuth is stowed
  assign el_dn = motion_q[aali_pkg::EL_DN_BIT] & ~motion_q[aali_pkg::EL_UP_BIT] & ~el_stowed
                 & ~(el_below & ~az_stowed); // R8 R2
  assign pol_cw = motion_q[aali_pkg::POL_CW_BIT] & ~motion_q[aali_pkg::POL_CCW_BIT];
  assign pol_ccw = motion_q[aali_pkg::POL_CCW_BIT] & ~motion_q[aali_pkg::POL_CW_BIT];

  // Terminal drive, registered so that the pins never glitch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      az_pos_o <= 1'b0;
      az_neg_o <= 1'b0;
      el_pos_o <= 1'b0;
      el_neg_o <= 1'b0;
      pol_one_o <= 1'b0;
      pol_two_o <= 1'b0;
    end else if (ce_i) begin
      az_pos_o <= az_cw; // R10 R13
      az_neg_o <= az_ccw; // R10
      el_pos_o <= el_up; // R11 R14
      el_neg_o <= el_dn; // R11
      // High-voltage variant swaps the polarization pair
      pol_one_o <= config_q[aali_pkg::POL_HV_BIT] ? pol_cw : pol_ccw; // R12 R15
      pol_two_o <= config_q[aali_pkg::POL_HV_BIT] ? pol_ccw : pol_cw; // R12 R15
    end
  end

  // Lock routing, inhibit and status outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strength_chan_one_lock_o <= 1'b0;
      strength_chan_two_lock_o <= 1'b0;
      peak_qualify_o <= 1'b0;
      amplifier_inhibit_o <= 1'b1;
    end else if (ce_i) begin
      strength_chan_one_lock_o <= deb_q[4]; // R16
      strength_chan_two_lock_o <= deb_q[5]; // R16
      peak_qualify_o <= config_q[aali_pkg::LOCK_SEL_BIT] ? deb_q[5] : deb_q[4]; // R17
      amplifier_inhibit_o <= el_below | motion_q[aali_pkg::AUTO_MOVE_BIT]; // R19
    end
  end

  assign gpio_o = gpio_out_q;
  assign gpio_oe_o = gpio_oe_q;

  // ==========================================================================
  // Read data; unmapped addresses read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (ce_i && wb_req) begin
      case (wb_adr_i)
        aali_pkg::ADDR_MOTION: wb_dat_o <= motion_q;
        aali_pkg::ADDR_CONFIG: wb_dat_o <= config_q;
        aali_pkg::ADDR_STATUS: wb_dat_o <= {24'h00_0000, amplifier_inhibit_o, peak_qualify_o, deb_q[5], deb_q[4],
                                            el_stowed, el_below, el_up_lim, az_stowed};
        aali_pkg::ADDR_GPIO_OUT: wb_dat_o <= 32'(gpio_out_q);
        aali_pkg::ADDR_GPIO_OE: wb_dat_o <= 32'(gpio_oe_q);
        aali_pkg::ADDR_GPIO_IN: wb_dat_o <= 32'(gin_q); // R18
        default: wb_dat_o <= '0;
      endcase
    end
  end

  // ==========================================================================
  // Checks
  property p_az_block;
    @(posedge clk_i) disable iff (rst_i) (ce_i && el_below) |=> (!az_pos_o && !az_neg_o);
  endproperty
  a_az_block: assert property (p_az_block) else $error("Azimuth driven below lower limit"); // R6

  property p_up_block;
    @(posedge clk_i) disable iff (rst_i) (ce_i && el_up_lim) |=> !el_pos_o;
  endproperty
  a_up_block: assert property (p_up_block) else $error("Elevation up driven at upper limit"); // R4

  property p_stow_block;
    @(posedge clk_i) disable iff (rst_i) (ce_i && el_stowed) |=> !el_neg_o;
  endproperty
  a_stow_block: assert property (p_stow_block) else $error("Elevation down driven while stowed"); // R8

  property p_below_az;
    @(posedge clk_i) disable iff (rst_i) (ce_i && el_below && !az_stowed) |=> !el_neg_o;
  endproperty
  a_below_az: assert property (p_below_az) else $error("Elevation down below limit without azimuth stow"); // R2

  property p_stow_below;
    @(posedge clk_i) disable iff (rst_i) (ce_i && el_stowed) |=> (amplifier_inhibit_o && !az_pos_o && !az_neg_o);
  endproperty
  a_stow_below: assert property (p_stow_below) else $error("Stow did not force below indication"); // R9

  property p_inhibit;
    @(posedge clk_i) disable iff (rst_i) (ce_i && (el_below || motion_q[aali_pkg::AUTO_MOVE_BIT])) |=> amplifier_inhibit_o;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("Amplifier inhibit not held"); // R19

  property p_az_pair;
    @(posedge clk_i) disable iff (rst_i) !(az_pos_o && az_neg_o) && !(el_pos_o && el_neg_o);
  endproperty
  a_az_pair: assert property (p_az_pair) else $error("Both terminals of an axis driven"); // R10 R11

  property p_lock_pair;
    @(posedge clk_i) disable iff (rst_i) ce_i |=> (strength_chan_one_lock_o == $past(deb_q[4]));
  endproperty
  a_lock_pair: assert property (p_lock_pair) else $error("Lock one not paired with channel one"); // R16

  property p_ack_once;
    @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> (!wb_ack_o || !ce_i);
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("Ack held two cycles");

  // Routing, bus and debounce checks
  property p_lock_two;
    @(posedge clk_i) disable iff (rst_i) ce_i |=> (strength_chan_two_lock_o == $past(deb_q[5]));
  endproperty
  a_lock_two: assert property (p_lock_two) else $error("Lock two not paired with channel two"); // R16

  property p_peak_sel;
    @(posedge clk_i) disable iff (rst_i)
      ce_i |=> (peak_qualify_o == ($past(config_q[aali_pkg::LOCK_SEL_BIT]) ? $past(deb_q[5]) : $past(deb_q[4])));
  endproperty
  a_peak_sel: assert property (p_peak_sel) else $error("Peaking qualifier not the selected lock"); // R17

  property p_pol_cw;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && pol_cw) |=> (pol_one_o == $past(config_q[aali_pkg::POL_HV_BIT])) && (pol_two_o != pol_one_o);
  endproperty
  a_pol_cw: assert property (p_pol_cw) else $error("Polarization clockwise terminal wrong for variant"); // R12

  property p_gpio_out;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && wb_wr && wb_sel_i[0] && wb_adr_i == aali_pkg::ADDR_GPIO_OUT)
      |=> (gpio_o == $past(wb_dat_i[GPIO_W-1:0]));
  endproperty
  a_gpio_out: assert property (p_gpio_out) else $error("Expansion output bits not written"); // R18

  sequence s_bus_req;
    ce_i && wb_req;
  endsequence
  property p_ack_next;
    @(posedge clk_i) disable iff (rst_i) s_bus_req |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("Bus request not answered");

  property p_deb_hold;
    @(posedge clk_i) disable iff (rst_i)
      ce_i |=> (((deb_q ^ $past(deb_q)) & ($past(s2_q) ^ $past(s3_q))) == '0);
  endproperty
  a_deb_hold: assert property (p_deb_hold) else $error("Contact accepted while stages disagree"); // R20

endmodule : aali_top

// ---- aali_field_model.sv ----
// Field model: limit contacts and position sensors of the three-axis positioner
`timescale 1ns/1ps
module aali_field_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Field state chosen by the bench
  input wire logic az_at_stow_i,
  input wire logic [1:0] el_zone_i,
  input wire logic [3:0] cut_i,
  // Motor terminals from the block
  input wire logic az_pos_i,
  input wire logic az_neg_i,
  input wire logic el_pos_i,
  input wire logic el_neg_i,
  // Contacts, high = closed
  output logic az_stow_closed_o,
  output logic el_up_closed_o,
  output logic el_dn_closed_o,
  output logic el_stow_closed_o,
  // Sensed positions
  output logic [15:0] az_sense_o,
  output logic [15:0] el_sense_o
);
  logic [15:0] az_q;
  logic [15:0] el_q;
  // ==========================================================================
  // Contacts; zone 0 stow, 1 below down limit, 2 travel, 3 up limit
  // A cut cable always reads open, so the block must fail safe on it
  assign az_stow_closed_o = az_at_stow_i & ~cut_i[0];
  assign el_up_closed_o = (el_zone_i != 2'h3) & ~cut_i[1];
  assign el_dn_closed_o = (el_zone_i >= 2'h2) & ~cut_i[2];
  assign el_stow_closed_o = (el_zone_i != 2'h0) & ~cut_i[3];
  // ==========================================================================
  // Sensed position rises with clockwise azimuth and upward elevation
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      az_q <= 16'h8000;
    end else begin
      az_q <= az_q + 16'(az_pos_i & ~az_neg_i) - 16'(az_neg_i & ~az_pos_i);
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      el_q <= 16'h8000;
    end else begin
      el_q <= el_q + 16'(el_pos_i & ~el_neg_i) - 16'(el_neg_i & ~el_pos_i);
    end
  end
  assign az_sense_o = az_q;
  assign el_sense_o = el_q;
endmodule : aali_field_model

// ---- aali_top_tb_top.sv ----
// Self-checking bench: random field states, motion commands and register traffic
`timescale 1ns/1ps
module aali_top_tb_top;
  typedef struct {logic rd; logic [31:0] exp;} aali_note_t;
  aali_note_t notes[$];
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic samp = 1'h0;
  logic ce = 1'h1;
  logic wb_cyc = 1'h0, wb_stb = 1'h0, wb_we = 1'h0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0000_0000, wb_dat_o;
  logic wb_ack_o, az_st, el_st, s1, s2, pq, azp, azn, elp, eln, p1, p2, inh;
  logic lock_one = 1'h0, lock_two = 1'h0, az_at_stow = 1'h0;
  logic [1:0] el_zone = 2'h2;
  logic [3:0] cut = 4'h0, gpio_in = 4'h0, gpio_o, gpio_oe;
  logic up_c, dn_c, stow_c;
  logic [31:0] seed = 32'h89d7_ba82;
  int err_total = 0;
  int checks_done = 0;
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  // ==========================================================================
  // Block under test and its field
  aali_top #(.DEB_CNT(4)) uut (.clk_i(clk_i), .ce_i(ce), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .az_stow_closed_i(az_st), .el_up_closed_i(up_c), .el_dn_closed_i(dn_c),
    .el_stow_closed_i(stow_c), .lock_one_i(lock_one), .lock_two_i(lock_two), .strength_chan_one_lock_o(s1),
    .strength_chan_two_lock_o(s2), .peak_qualify_o(pq), .az_pos_o(azp), .az_neg_o(azn), .el_pos_o(elp),
    .el_neg_o(eln), .pol_one_o(p1), .pol_two_o(p2), .amplifier_inhibit_o(inh), .gpio_i(gpio_in),
    .gpio_o(gpio_o), .gpio_oe_o(gpio_oe));
  aali_field_model field (.clk_i(clk_i), .rst_i(rst_i), .az_at_stow_i(az_at_stow), .el_zone_i(el_zone),
    .cut_i(cut), .az_pos_i(azp), .az_neg_i(azn), .el_pos_i(elp), .el_neg_i(eln), .az_stow_closed_o(az_st),
    .el_up_closed_o(up_c), .el_dn_closed_o(dn_c), .el_stow_closed_o(stow_c), .az_sense_o(), .el_sense_o());
  // ==========================================================================
  // Shared tasks
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    if (err_total == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  // Classic single cycle; held until ack is sampled high
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} <= {2'h3, w, a, d};
    @(posedge clk_i iff wb_ack_o);
    {wb_cyc, wb_stb} <= 2'h0;
  endtask : wb_cycle
  task automatic wb_read(input logic [7:0] a, input logic [31:0] exp);
    notes.push_back('{1'h1, exp});
    wb_cycle(1'h0, a, 32'h0000_0000);
  endtask : wb_read
  // Port snapshot taken at exactly one edge
  task automatic sample_ports(input logic [31:0] exp);
    notes.push_back('{1'h0, exp});
    samp <= 1'h1;
    @(posedge clk_i);
    samp <= 1'h0;
  endtask : sample_ports
  // ==========================================================================
  // Watcher: oldest note against each read answer or port snapshot
  always @(posedge clk_i) begin
    aali_note_t n;
    logic [31:0] v;
    if ((wb_ack_o && !wb_we) || samp) begin
      n = notes.pop_front();
      v = n.rd ? wb_dat_o : {14'h0000, pq, s2, s1, gpio_oe, gpio_o, azp, azn, elp, eln, p1, p2, inh};
      check(n.rd ? "read data" : "ports", v, n.exp);
    end
  end
  // Watchdog, far beyond the expected run of about 2600 cycles
  initial begin
    #100000;
    err_total++;
    finish_test();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    logic [31:0] t;
    logic [6:0] m, d;
    logic [1:0] c;
    logic a_s, up_l, el_s, below, pc, pw;
    repeat (10) @(posedge clk_i);
    sample_ports(32'h0000_0001);
    @(posedge clk_i);
    rst_i <= 1'h0;
    wb_read(aali_pkg::ADDR_MOTION, aali_pkg::MOTION_RST);
    wb_read(aali_pkg::ADDR_CONFIG, aali_pkg::CONFIG_RST);
    wb_read(aali_pkg::ADDR_GPIO_OE, {28'h000_0000, aali_pkg::GPIO_RST});
    // Unmapped place and read-only status must ignore writes
    wb_cycle(1'h1, 8'h18, seed);
    wb_read(8'h18, 32'h0000_0000);
    wb_cycle(1'h1, aali_pkg::ADDR_STATUS, 32'hffff_ffff);
    for (int i = 0; i < 60; i++) begin
      repeat (32) seed = lfsr(seed);
      t = seed;
      repeat (32) seed = lfsr(seed);
      {az_at_stow, el_zone, lock_one, lock_two, gpio_in} <= {seed[2:0], seed[4:3], t[11:8]};
      cut <= seed[8:5] & seed[12:9] & seed[16:13];
      m = seed[23:17];
      c = seed[25:24];
      wb_cycle(1'h1, aali_pkg::ADDR_CONFIG, {30'h0000_0000, c});
      wb_cycle(1'h1, aali_pkg::ADDR_MOTION, {25'h000_0000, m});
      wb_cycle(1'h1, aali_pkg::ADDR_GPIO_OUT, {28'h000_0000, t[3:0]});
      wb_cycle(1'h1, aali_pkg::ADDR_GPIO_OE, {28'h000_0000, t[7:4]});
      repeat (20) @(posedge clk_i);
      // Conditions worked out from the field state
      a_s = az_at_stow & ~cut[0];
      up_l = (el_zone == 2'h3) | cut[1];
      el_s = (el_zone == 2'h0) | cut[3];
      below = (el_zone < 2'h2) | cut[2] | el_s;
      pc = m[4] & ~m[5];
      pw = m[5] & ~m[4];
      d[6] = m[0] & ~m[1] & ~below;
      d[5] = m[1] & ~m[0] & ~below;
      d[4] = m[2] & ~m[3] & ~up_l;
      d[3] = m[3] & ~m[2] & ~el_s & (~below | a_s);
      d[2] = c[1] ? pc : pw;
      d[1] = c[1] ? pw : pc;
      d[0] = below | m[6];
      sample_ports({14'h0000, c[0] ? lock_two : lock_one, lock_two, lock_one, t[7:4], t[3:0], d});
      wb_read(aali_pkg::ADDR_STATUS, {24'h00_0000, d[0], c[0] ? lock_two : lock_one, lock_two, lock_one, el_s,
        below, up_l, a_s});
      wb_read(aali_pkg::ADDR_GPIO_IN, {28'h000_0000, t[11:8]});
      wb_read(aali_pkg::ADDR_MOTION, {25'h000_0000, m});
    end
    // Frozen enable: a cut harness must not reach the terminals until enable returns
    ce <= 1'h0;
    cut <= 4'hf;
    repeat (20) @(posedge clk_i);
    sample_ports({14'h0000, c[0] ? lock_two : lock_one, lock_two, lock_one, t[7:4], t[3:0], d});
    ce <= 1'h1;
    repeat (20) @(posedge clk_i);
    d = {4'h0, d[2:1], 1'h1};
    sample_ports({14'h0000, c[0] ? lock_two : lock_one, lock_two, lock_one, t[7:4], t[3:0], d});
    wb_read(aali_pkg::ADDR_STATUS, {24'h00_0000, 1'h1, c[0] ? lock_two : lock_one, lock_two, lock_one, 4'he});
    // Reset in mid-run returns every output to its idle level
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    sample_ports(32'h0000_0001);
    rst_i <= 1'h0;
    wb_read(aali_pkg::ADDR_MOTION, aali_pkg::MOTION_RST);
    repeat (4) @(posedge clk_i);
    finish_test();
  end
endmodule : aali_top_tb_top
